//--- rtl/periph_clock_select_and_key.sv
`timescale 1ns/100ps
`default_nettype none
module periph_clock_select_and_key
	import clock_select_pkg::*;
#(
	parameter bit SECOND_VARIANT = 1'b0
) (
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	input  wire logic [11:0]  bus_addr_i,
	input  wire logic         bus_write_i,
	input  wire logic         bus_read_i,
	input  wire logic [3:0]   bus_strobe_i,
	input  wire logic [31:0]  bus_wdata_i,
	output logic      [31:0]  bus_rdata_o,
	output logic              bus_rvalid_o,
	output clock_route_t      clock_route_o,
	output logic      [2:0]   mid_rc_divide_shift_o,
	output ahb2_control_t     ahb2_control_o,
	output logic      [3:0]   bandgap_hold_length_o,
	output logic      [15:0]  hold_phase_cycles_o
);

	localparam logic [31:0] ACTIVE_KEY    = SECOND_VARIANT ? UNLOCK_KEY_B : UNLOCK_KEY_A;
	localparam logic [3:0]  BANDGAP_RESET = SECOND_VARIANT ? BANDGAP_RESET_B : BANDGAP_RESET_A;
	localparam logic [3:0]  BANDGAP_MASK  = SECOND_VARIANT ? 4'hF : 4'h7;

	logic [31:0] clock_select;
	logic [31:0] ahb2_enable;
	logic [31:0] ahb2_reset;
	logic [31:0] key_shadow;
	logic [3:0]  bandgap_mode;
	logic        unlocked;
	logic [31:0] next_key;
	logic        write_select;
	logic        write_enable;
	logic        write_reset;
	logic        write_key;
	logic        write_bandgap;

	// Merges the strobed byte lanes of a write into the old value.
	function automatic logic [31:0] merge_lanes(input logic [31:0] old_value,
		input logic [31:0] new_value, input logic [3:0] strobe);
		logic [31:0] result;
		result = old_value;
		for (int lane = 0; lane < 4; lane++) begin
			if (strobe[lane]) begin
				result[lane*8 +: 8] = new_value[lane*8 +: 8];
			end
		end
		return result;
	endfunction : merge_lanes

	// Decodes the common four-way selector used by timers and serial ports.
	function automatic clock_source_t pick_four(input logic [1:0] code,
		input clock_source_t bus_src, input clock_source_t second_src);
		clock_source_t result;
		unique case (code)
			2'b00: result = bus_src;
			2'b01: result = second_src;
			2'b10: result = SRC_SLOW_CRYSTAL;
			2'b11: result = SRC_MID_RC_DIV;
		endcase
		return result;
	endfunction : pick_four

	// Decodes an I2C selector where both upper codes choose the divided RC.
	function automatic clock_source_t pick_i2c(input logic [1:0] code);
		clock_source_t result;
		unique case (code)
			2'b00: result = SRC_APB1;
			2'b01: result = SRC_SYSTEM;
			2'b10, 2'b11: result = SRC_MID_RC_DIV;
		endcase
		return result;
	endfunction : pick_i2c

	// Address decode of writes; every access width is honoured by its strobes.
	assign write_select  = bus_write_i && bus_addr_i == CLOCK_SELECT_OFFSET;
	assign write_enable  = bus_write_i && bus_addr_i == AHB2_ENABLE_OFFSET;
	assign write_reset   = bus_write_i && bus_addr_i == AHB2_RESET_OFFSET;
	assign write_key     = bus_write_i && bus_addr_i == UNLOCK_KEY_OFFSET;
	assign write_bandgap = bus_write_i && bus_addr_i == BANDGAP_MODE_OFFSET;
	assign next_key      = merge_lanes(key_shadow, bus_wdata_i, bus_strobe_i);

	// Clock source select register; only the defined fields are kept.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			clock_select <= CLOCK_SELECT_RESET;
		end else if (write_select) begin
			clock_select <= merge_lanes(clock_select, bus_wdata_i, bus_strobe_i)
				& CLOCK_SELECT_MASK;
		end
	end

	// AHB2 enable register holds the random and cipher unit clock gates.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ahb2_enable <= AHB2_ENABLE_RESET;
		end else if (write_enable) begin
			ahb2_enable <= merge_lanes(ahb2_enable, bus_wdata_i, bus_strobe_i)
				& ((32'h0000_0001 << RANDOM_POS) | (32'h0000_0001 << CIPHER_POS));
		end
	end

	// AHB2 reset register holds the random and cipher unit resets.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ahb2_reset <= AHB2_RESET_RESET;
		end else if (write_reset) begin
			ahb2_reset <= merge_lanes(ahb2_reset, bus_wdata_i, bus_strobe_i)
				& ((32'h0000_0001 << RANDOM_POS) | (32'h0000_0001 << CIPHER_POS));
		end
	end

	// Key shadow collects partial writes so a key may arrive by bytes.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			key_shadow <= UNLOCK_KEY_RESET;
		end else if (write_key) begin
			key_shadow <= next_key;
		end
	end

	// Lock: a correct key opens one bandgap write; any other key closes it.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			unlocked <= 1'b0;
		end else if (write_key) begin
			unlocked <= next_key == ACTIVE_KEY;
		end else if (write_bandgap) begin
			unlocked <= 1'b0;
		end
	end

	// Bandgap mode register, written only while unlocked.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			bandgap_mode <= BANDGAP_RESET;
		end else if (write_bandgap && unlocked && bus_strobe_i[0]) begin
			bandgap_mode <= bus_wdata_i[3:0] & BANDGAP_MASK;
		end
	end

	// Read data, one cycle after the read; the key always reads as zero.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			bus_rdata_o  <= 32'h0000_0000;
			bus_rvalid_o <= 1'b0;
		end else begin
			bus_rvalid_o <= bus_read_i;
			if (bus_read_i) begin
				unique case (bus_addr_i)
					CLOCK_SELECT_OFFSET: bus_rdata_o <= clock_select;
					AHB2_ENABLE_OFFSET:  bus_rdata_o <= ahb2_enable;
					AHB2_RESET_OFFSET:   bus_rdata_o <= ahb2_reset;
					BANDGAP_MODE_OFFSET: bus_rdata_o <= {28'h000_0000, bandgap_mode};
					default:             bus_rdata_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Kernel clock routing decoded from the select fields.
	always_comb begin
		clock_route_o.lowpower_timer_b_src  = pick_four(clock_select[TIMER_B_POS +: 2],
			SRC_APB1, SRC_SLOW_RC);
		clock_route_o.serial_port_b_src     = pick_four(clock_select[SERIAL_B_POS +: 2],
			SRC_APB1, SRC_SYSTEM);
		clock_route_o.usb_device_src        = clock_select[USB_POS] ? SRC_PLL
			: SRC_HIGH_RC;
		clock_route_o.lowpower_serial_a_src = pick_four(clock_select[LP_SERIAL_POS +: 2],
			SRC_APB1, SRC_SYSTEM);
		clock_route_o.lowpower_timer_a_src  = pick_four(clock_select[TIMER_A_POS +: 2],
			SRC_APB1, SRC_SLOW_RC);
		clock_route_o.converter_clock_src   = clock_select[CONVERTER_POS] ? SRC_BUS_PRESCALED
			: SRC_MID_RC;
		clock_route_o.i2c_port_c_src        = pick_i2c(clock_select[I2C_C_POS +: 2]);
		clock_route_o.i2c_port_b_src        = pick_i2c(clock_select[I2C_B_POS +: 2]);
		clock_route_o.i2c_port_a_src        = pick_i2c(clock_select[I2C_A_POS +: 2]);
		clock_route_o.serial_port_a_src     = pick_four(clock_select[SERIAL_A_POS +: 2],
			SRC_APB2, SRC_SYSTEM);
	end

	// Divider as a shift: 0 passes the mid RC clock, 1..4 divide by 2..16.
	assign mid_rc_divide_shift_o = clock_select[DIVIDER_POS + 2]
		? {1'b0, clock_select[DIVIDER_POS +: 2]} + 3'd1 : 3'd0;

	// AHB2 unit gates and resets, and the bandgap mode output.
	assign ahb2_control_o.random_unit_clock_on = ahb2_enable[RANDOM_POS];
	assign ahb2_control_o.cipher_unit_clock_on = ahb2_enable[CIPHER_POS];
	assign ahb2_control_o.random_unit_reset    = ahb2_reset[RANDOM_POS];
	assign ahb2_control_o.cipher_unit_reset    = ahb2_reset[CIPHER_POS];
	assign bandgap_hold_length_o               = bandgap_mode;

	// Hold phase length in clock cycles from the bandgap mode field.
	always_comb begin
		logic [3:0] step;
		logic [4:0] units;
		step  = {~bandgap_mode[3], bandgap_mode[2], ~bandgap_mode[1:0]};
		units = 5'd0;
		if (!SECOND_VARIANT) begin
			step[3] = 1'b0;
		end
		unique case (step)
			4'd0:  units = 5'd1;
			4'd1:  units = 5'd2;
			4'd2:  units = 5'd3;
			4'd3:  units = 5'd4;
			4'd4:  units = 5'd5;
			4'd5:  units = 5'd6;
			4'd6:  units = 5'd7;
			4'd7:  units = SECOND_VARIANT ? 5'd31 : 5'd7;
			4'd8:  units = 5'd8;
			4'd9:  units = 5'd20;
			4'd10: units = 5'd21;
			4'd11: units = 5'd22;
			4'd12: units = 5'd9;
			4'd13: units = 5'd23;
			4'd14: units = 5'd24;
			4'd15: units = 5'd10;
		endcase
		// Codes 1..10 are powers of two, 20..24 and 31 other multiples of 1024.
		unique case (units)
			5'd20:   hold_phase_cycles_o = 16'(5 * 1024);
			5'd21:   hold_phase_cycles_o = 16'(6 * 1024);
			5'd22:   hold_phase_cycles_o = 16'(7 * 1024);
			5'd23:   hold_phase_cycles_o = 16'(10 * 1024);
			5'd24:   hold_phase_cycles_o = 16'(12 * 1024);
			5'd31:   hold_phase_cycles_o = 16'(3 * 1024);
			default: hold_phase_cycles_o = 16'(HOLD_UNIT_CYCLES << (units - 5'd1));
		endcase
	end

	default clocking main_clk @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// Key register never returns its contents.
	key_reads_zero_a: assert property (bus_read_i
		&& bus_addr_i == UNLOCK_KEY_OFFSET
		|=> bus_rvalid_o && bus_rdata_o == 32'h0000_0000)
		else $error("key register read returned nonzero data");

	// Bandgap mode holds when written without a fresh correct key.
	bandgap_locked_a: assert property (write_bandgap && !unlocked
		|=> $stable(bandgap_hold_length_o))
		else $error("bandgap mode changed while locked");

	// Correct full key then write updates the bandgap mode.
	key_unlocks_a: assert property (bus_write_i
		&& bus_addr_i == UNLOCK_KEY_OFFSET
		&& bus_strobe_i == 4'hF && bus_wdata_i == ACTIVE_KEY
		##1 bus_write_i && bus_addr_i == BANDGAP_MODE_OFFSET && bus_strobe_i[0]
		|=> bandgap_hold_length_o == ($past(bus_wdata_i[3:0]) & BANDGAP_MASK))
		else $error("correct key did not unlock bandgap write");

	// Wrong full key leaves the bandgap register locked.
	wrong_key_locks_a: assert property (bus_write_i
		&& bus_addr_i == UNLOCK_KEY_OFFSET
		&& bus_strobe_i == 4'hF && bus_wdata_i != ACTIVE_KEY
		##1 write_bandgap |=> $stable(bandgap_hold_length_o))
		else $error("wrong key unlocked bandgap write");

	// Random unit clock follows a byte write to the enable register.
	random_clock_write_a: assert property (write_enable && bus_strobe_i[0]
		|=> ahb2_control_o.random_unit_clock_on == $past(bus_wdata_i[RANDOM_POS]))
		else $error("random unit clock gate did not follow write");

	// Cipher reset follows a byte write to the reset register.
	cipher_reset_write_a: assert property (write_reset && bus_strobe_i[0]
		|=> ahb2_control_o.cipher_unit_reset == $past(bus_wdata_i[CIPHER_POS]))
		else $error("cipher unit reset did not follow write");

	// Random unit reset follows the reset register bit.
	random_reset_write_a: assert property (write_reset && bus_strobe_i[0]
		|=> ahb2_control_o.random_unit_reset == $past(bus_wdata_i[RANDOM_POS]))
		else $error("random unit reset did not follow write");

	// Divider code 111 gives divide by sixteen, 0xx gives passthrough.
	divider_code_a: assert property (write_select && bus_strobe_i[2]
		|=> mid_rc_divide_shift_o == ($past(bus_wdata_i[20]) ? 3'd1
		+ {1'b0, $past(bus_wdata_i[19:18])} : 3'd0))
		else $error("divider shift does not match written code");

	// Upper I2C port A codes both pick the divided RC clock.
	i2c_upper_code_a: assert property (clock_select[I2C_A_POS + 1]
		|-> clock_route_o.i2c_port_a_src == SRC_MID_RC_DIV)
		else $error("i2c upper code did not select divided clock");

	// Cipher unit clock gate follows a byte write to the enable register.
	cipher_clock_write_a: assert property (write_enable && bus_strobe_i[0]
		|=> ahb2_control_o.cipher_unit_clock_on == $past(bus_wdata_i[CIPHER_POS]))
		else $error("cipher unit clock gate did not follow write");

	// USB device source follows its select bit.
	usb_source_a: assert property (write_select && bus_strobe_i[1]
		|=> clock_route_o.usb_device_src
		== ($past(bus_wdata_i[USB_POS]) ? SRC_PLL : SRC_HIGH_RC))
		else $error("usb device source does not match select bit");

	// Converter clock follows its select bit.
	converter_source_a: assert property (write_select && bus_strobe_i[1]
		|=> clock_route_o.converter_clock_src
		== ($past(bus_wdata_i[CONVERTER_POS]) ? SRC_BUS_PRESCALED : SRC_MID_RC))
		else $error("converter clock source does not match select bit");

	// Timer B code 01 picks the slow RC clock.
	timer_b_slow_rc_a: assert property (write_select && bus_strobe_i[2]
		&& bus_wdata_i[TIMER_B_POS +: 2] == 2'b01
		|=> clock_route_o.lowpower_timer_b_src == SRC_SLOW_RC)
		else $error("timer b code 01 did not select slow rc clock");

	// Serial B code 01 picks the system clock.
	serial_b_system_a: assert property (write_select && bus_strobe_i[2]
		&& bus_wdata_i[SERIAL_B_POS +: 2] == 2'b01
		|=> clock_route_o.serial_port_b_src == SRC_SYSTEM)
		else $error("serial b code 01 did not select system clock");

	// Low-power serial A code 10 picks the crystal clock.
	lp_serial_crystal_a: assert property (write_select && bus_strobe_i[1]
		&& bus_wdata_i[LP_SERIAL_POS +: 2] == 2'b10
		|=> clock_route_o.lowpower_serial_a_src == SRC_SLOW_CRYSTAL)
		else $error("low power serial code 10 did not select crystal clock");

	// Timer A code 01 picks the slow RC clock.
	timer_a_slow_rc_a: assert property (write_select && bus_strobe_i[1]
		&& bus_wdata_i[TIMER_A_POS +: 2] == 2'b01
		|=> clock_route_o.lowpower_timer_a_src == SRC_SLOW_RC)
		else $error("timer a code 01 did not select slow rc clock");

	// Serial A code 00 picks the APB2 bus clock.
	serial_a_apb2_a: assert property (write_select && bus_strobe_i[0]
		&& bus_wdata_i[SERIAL_A_POS +: 2] == 2'b00
		|=> clock_route_o.serial_port_a_src == SRC_APB2)
		else $error("serial a code 00 did not select apb2 clock");

	// Reserved enable bits always read back as zero.
	enable_reserved_a: assert property (bus_read_i
		&& bus_addr_i == AHB2_ENABLE_OFFSET
		|=> (bus_rdata_o & 32'hFFFF_FFF5) == 32'h0000_0000)
		else $error("reserved enable bits read nonzero");

	// Bandgap mode reads back as it is stored.
	bandgap_readback_a: assert property (bus_read_i
		&& bus_addr_i == BANDGAP_MODE_OFFSET
		|=> bus_rdata_o == {28'h000_0000, $past(bandgap_hold_length_o)})
		else $error("bandgap mode read back wrong value");

	// A write that skips lane 0 leaves the unit gates alone.
	enable_lane_keep_a: assert property (write_enable
		&& !bus_strobe_i[0]
		|=> $stable(ahb2_control_o))
		else $error("enable write without lane 0 changed unit gates");

endmodule : periph_clock_select_and_key
`default_nettype wire

//--- include/clock_select_pkg.sv
package clock_select_pkg;

	// Register byte offsets.
	localparam logic [11:0] CLOCK_SELECT_OFFSET  = 12'h030;
	localparam logic [11:0] AHB2_ENABLE_OFFSET   = 12'h034;
	localparam logic [11:0] AHB2_RESET_OFFSET    = 12'h038;
	localparam logic [11:0] UNLOCK_KEY_OFFSET    = 12'h100;
	localparam logic [11:0] BANDGAP_MODE_OFFSET  = 12'h12C;

	// Reset values.
	localparam logic [31:0] CLOCK_SELECT_RESET   = 32'h0000_0000;
	localparam logic [31:0] AHB2_ENABLE_RESET    = 32'h0000_0000;
	localparam logic [31:0] AHB2_RESET_RESET     = 32'h0000_0000;
	localparam logic [31:0] UNLOCK_KEY_RESET     = 32'h0000_0000;
	localparam logic [3:0]  BANDGAP_RESET_A      = 4'h7;
	localparam logic [3:0]  BANDGAP_RESET_B      = 4'hF;

	// Unlock keys of the two variants.
	localparam logic [31:0] UNLOCK_KEY_A         = 32'h1A2B_3C4D;
	localparam logic [31:0] UNLOCK_KEY_B         = 32'h0000_7432;

	// Writable bits of the clock select register.
	localparam logic [31:0] CLOCK_SELECT_MASK    = 32'h007F_3FFF;

	// Field positions.
	localparam int TIMER_B_POS   = 21;
	localparam int DIVIDER_POS   = 18;
	localparam int SERIAL_B_POS  = 16;
	localparam int USB_POS       = 13;
	localparam int LP_SERIAL_POS = 11;
	localparam int TIMER_A_POS   = 9;
	localparam int CONVERTER_POS = 8;
	localparam int I2C_C_POS     = 6;
	localparam int I2C_B_POS     = 4;
	localparam int I2C_A_POS     = 2;
	localparam int SERIAL_A_POS  = 0;
	localparam int RANDOM_POS    = 3;
	localparam int CIPHER_POS    = 1;

	// Hold phase length unit in cycles of the sample-and-hold clock.
	localparam int HOLD_UNIT_CYCLES = 32;

	// Clock sources a kernel clock can be routed from.
	typedef enum logic [3:0] {
		SRC_APB1,
		SRC_APB2,
		SRC_SYSTEM,
		SRC_SLOW_RC,
		SRC_SLOW_CRYSTAL,
		SRC_MID_RC_DIV,
		SRC_MID_RC,
		SRC_HIGH_RC,
		SRC_PLL,
		SRC_BUS_PRESCALED
	} clock_source_t;

	// Decoded routing for every kernel clock.
	typedef struct packed {
		clock_source_t lowpower_timer_b_src;
		clock_source_t serial_port_b_src;
		clock_source_t usb_device_src;
		clock_source_t lowpower_serial_a_src;
		clock_source_t lowpower_timer_a_src;
		clock_source_t converter_clock_src;
		clock_source_t i2c_port_c_src;
		clock_source_t i2c_port_b_src;
		clock_source_t i2c_port_a_src;
		clock_source_t serial_port_a_src;
	} clock_route_t;

	// Gating and reset for the AHB2 units.
	typedef struct packed {
		logic random_unit_clock_on;
		logic cipher_unit_clock_on;
		logic random_unit_reset;
		logic cipher_unit_reset;
	} ahb2_control_t;

endpackage : clock_select_pkg

//--- testbench/periph_clock_select_and_key_tb.sv
`timescale 1ns/100ps
`default_nettype none
module periph_clock_select_and_key_tb
	import clock_select_pkg::*;
;
	logic          clk_i;
	logic          rst_n_i;
	logic          bus_write_i;
	logic          bus_read_i;
	logic          bus_rvalid_o;
	logic [11:0]   bus_addr_i;
	logic [3:0]    bus_strobe_i;
	logic [31:0]   bus_wdata_i;
	logic [31:0]   bus_rdata_o;
	clock_route_t  clock_route_o;
	logic [2:0]    mid_rc_divide_shift_o;
	ahb2_control_t ahb2_control_o;
	logic [3:0]    bandgap_hold_length_o;
	logic [3:0]    mode_b;
	logic [15:0]   hold_phase_cycles_o;
	logic [15:0]   hold_b;
	int            n_fail;
	int            comparisons;
	clock_source_t t_tab[4] = '{SRC_APB1, SRC_SLOW_RC, SRC_SLOW_CRYSTAL, SRC_MID_RC_DIV};
	clock_source_t s_tab[4] = '{SRC_APB1, SRC_SYSTEM, SRC_SLOW_CRYSTAL, SRC_MID_RC_DIV};
	clock_source_t i_tab[4] = '{SRC_APB1, SRC_SYSTEM, SRC_MID_RC_DIV, SRC_MID_RC_DIV};
	clock_source_t a_tab[4] = '{SRC_APB2, SRC_SYSTEM, SRC_SLOW_CRYSTAL, SRC_MID_RC_DIV};

	// First variant is fully observed; the second shares the bus and shows only its mode and hold phase length.
	periph_clock_select_and_key #(.SECOND_VARIANT(1'b0)) dut (.clk_i, .rst_n_i, .bus_addr_i,
		.bus_write_i, .bus_read_i, .bus_strobe_i, .bus_wdata_i, .bus_rdata_o, .bus_rvalid_o,
		.clock_route_o, .mid_rc_divide_shift_o, .ahb2_control_o, .bandgap_hold_length_o,
		.hold_phase_cycles_o);
	periph_clock_select_and_key #(.SECOND_VARIANT(1'b1)) dut_b (.clk_i, .rst_n_i, .bus_addr_i,
		.bus_write_i, .bus_read_i, .bus_strobe_i, .bus_wdata_i, .bus_rdata_o(), .bus_rvalid_o(),
		.clock_route_o(), .mid_rc_divide_shift_o(), .ahb2_control_o(),
		.bandgap_hold_length_o(mode_b), .hold_phase_cycles_o(hold_b));

	// Free-running 25 MHz clock.
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask : check

	// One write, then an idle cycle so the strobe is never raised twice in a time step.
	task automatic wr(input logic [11:0] a, input logic [3:0] s, input logic [31:0] d);
		bus_addr_i = a;
		bus_strobe_i = s;
		bus_wdata_i = d;
		bus_write_i = 1'b1;
		@(posedge clk_i);
		#1;
		bus_write_i = 1'b0;
		@(posedge clk_i);
		#1;
	endtask : wr

	// Key and bandgap writes back to back, with write held up across both.
	task automatic wr_pair(input logic [31:0] key, input logic [31:0] mode);
		bus_addr_i = UNLOCK_KEY_OFFSET;
		bus_strobe_i = 4'hF;
		bus_wdata_i = key;
		bus_write_i = 1'b1;
		@(posedge clk_i);
		#1;
		bus_addr_i = BANDGAP_MODE_OFFSET;
		bus_wdata_i = mode;
		@(posedge clk_i);
		#1;
		bus_write_i = 1'b0;
		@(posedge clk_i);
		#1;
	endtask : wr_pair

	// Read answers one cycle after the request, looked at while rvalid stands.
	task automatic rc(input string what, input logic [11:0] a, input logic [31:0] exp);
		bus_addr_i = a;
		bus_read_i = 1'b1;
		@(posedge clk_i);
		#1;
		bus_read_i = 1'b0;
		check("rvalid", {31'h0, bus_rvalid_o}, 32'h0000_0001);
		check(what, bus_rdata_o, exp);
		@(posedge clk_i);
		#1;
	endtask : rc

	task automatic do_reset;
		rst_n_i = 1'b0;
		repeat (5) @(posedge clk_i);
		#1;
		rst_n_i = 1'b1;
	endtask : do_reset

	task automatic give_verdict;
		$display("comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : give_verdict

	task automatic t_reset;
		check("control", 32'(ahb2_control_o), 32'h0000_0000);
		check("usb src", 32'(clock_route_o.usb_device_src), 32'(SRC_HIGH_RC));
		rc("select", CLOCK_SELECT_OFFSET, 32'h0000_0000);
		rc("enable", AHB2_ENABLE_OFFSET, 32'h0000_0000);
		rc("reset reg", AHB2_RESET_OFFSET, 32'h0000_0000);
		rc("key", UNLOCK_KEY_OFFSET, 32'h0000_0000);
		rc("mode reg", BANDGAP_MODE_OFFSET, 32'h0000_0007);
		check("mode", 32'(bandgap_hold_length_o), 32'h0000_0007);
		check("mode b", 32'(mode_b), 32'h0000_000F);
		check("hold", 32'(hold_phase_cycles_o), 32'h0000_0200);
		$display("reset test done");
	endtask : t_reset

	// Every field code and every divider code, one write per pattern.
	task automatic t_route;
		logic [1:0] f;
		logic       b;
		for (int c = 0; c < 8; c++) begin
			f = c[1:0];
			b = c[0];
			wr(CLOCK_SELECT_OFFSET, 4'hF, {9'h0, f, c[2:0], f, 2'b00, b, f, f, b, f, f, f, f});
			check("timer b", 32'(clock_route_o.lowpower_timer_b_src), 32'(t_tab[f]));
			check("divider", 32'(mid_rc_divide_shift_o), c[2] ? 32'(f) + 1 : 0);
			check("serial b", 32'(clock_route_o.serial_port_b_src), 32'(s_tab[f]));
			check("usb", 32'(clock_route_o.usb_device_src),
				32'(b ? SRC_PLL : SRC_HIGH_RC));
			check("lp serial", 32'(clock_route_o.lowpower_serial_a_src), 32'(s_tab[f]));
			check("timer a", 32'(clock_route_o.lowpower_timer_a_src), 32'(t_tab[f]));
			check("adc", 32'(clock_route_o.converter_clock_src),
				32'(b ? SRC_BUS_PRESCALED : SRC_MID_RC));
			check("i2c c", 32'(clock_route_o.i2c_port_c_src), 32'(i_tab[f]));
			check("i2c b", 32'(clock_route_o.i2c_port_b_src), 32'(i_tab[f]));
			check("i2c a", 32'(clock_route_o.i2c_port_a_src), 32'(i_tab[f]));
			check("serial a", 32'(clock_route_o.serial_port_a_src), 32'(a_tab[f]));
		end
		wr(CLOCK_SELECT_OFFSET, 4'hF, 32'hFFFF_FFFF);
		rc("select", CLOCK_SELECT_OFFSET, 32'h007F_3FFF);
		$display("route test done");
	endtask : t_route

	// Lane writes must touch only their own byte.
	task automatic t_ahb2;
		wr(AHB2_ENABLE_OFFSET, 4'hF, 32'hFFFF_FFFF);
		check("control", 32'(ahb2_control_o), 32'h0000_000C);
		rc("enable", AHB2_ENABLE_OFFSET, 32'h0000_000A);
		wr(AHB2_ENABLE_OFFSET, 4'hE, 32'h0000_0000);
		check("control", 32'(ahb2_control_o), 32'h0000_000C);
		wr(AHB2_ENABLE_OFFSET, 4'h1, 32'h0000_0008);
		check("control", 32'(ahb2_control_o), 32'h0000_0008);
		wr(AHB2_RESET_OFFSET, 4'h3, 32'hFFFF_0002);
		check("control", 32'(ahb2_control_o), 32'h0000_0009);
		wr(AHB2_RESET_OFFSET, 4'h1, 32'h0000_0008);
		check("control", 32'(ahb2_control_o), 32'h0000_000A);
		rc("reset reg", AHB2_RESET_OFFSET, 32'h0000_0008);
		$display("enable and reset test done");
	endtask : t_ahb2

	// Wrong key, right key, one-shot use, key by bytes, and the other variant's key.
	task automatic t_key;
		wr(UNLOCK_KEY_OFFSET, 4'hF, 32'h1A2B_3C4C);
		wr(BANDGAP_MODE_OFFSET, 4'hF, 32'h0000_0005);
		check("mode", 32'(bandgap_hold_length_o), 32'h0000_0007);
		wr(UNLOCK_KEY_OFFSET, 4'hF, UNLOCK_KEY_A);
		rc("key", UNLOCK_KEY_OFFSET, 32'h0000_0000);
		wr(BANDGAP_MODE_OFFSET, 4'hF, 32'h0000_0005);
		check("mode", 32'(bandgap_hold_length_o), 32'h0000_0005);
		check("mode b", 32'(mode_b), 32'h0000_000F);
		check("hold", 32'(hold_phase_cycles_o), 32'h0000_0800);
		rc("mode reg", BANDGAP_MODE_OFFSET, 32'h0000_0005);
		wr(BANDGAP_MODE_OFFSET, 4'hF, 32'h0000_0003);
		check("mode", 32'(bandgap_hold_length_o), 32'h0000_0005);
		wr_pair(32'h1A2B_3C4C, 32'h0000_0003);
		check("mode", 32'(bandgap_hold_length_o), 32'h0000_0005);
		wr_pair(UNLOCK_KEY_A, 32'h0000_0006);
		check("mode", 32'(bandgap_hold_length_o), 32'h0000_0006);
		check("hold", 32'(hold_phase_cycles_o), 32'h0000_0400);
		wr(UNLOCK_KEY_OFFSET, 4'hF, 32'h0000_0000);
		for (int i = 0; i < 4; i++) begin
			wr(UNLOCK_KEY_OFFSET, 4'h1 << i, UNLOCK_KEY_A & (32'h0000_00FF << (8 * i)));
			if (i == 2) begin
				wr(BANDGAP_MODE_OFFSET, 4'h1, 32'h0000_0002);
				check("mode", 32'(bandgap_hold_length_o), 32'h0000_0006);
			end
		end
		wr(BANDGAP_MODE_OFFSET, 4'h1, 32'h0000_0002);
		check("mode", 32'(bandgap_hold_length_o), 32'h0000_0002);
		check("hold", 32'(hold_phase_cycles_o), 32'h0000_0040);
		wr(UNLOCK_KEY_OFFSET, 4'hF, UNLOCK_KEY_B);
		wr(BANDGAP_MODE_OFFSET, 4'hF, 32'h0000_000C);
		check("mode b", 32'(mode_b), 32'h0000_000C);
		check("hold b", 32'(hold_b), 32'h0000_0C00);
		check("mode", 32'(bandgap_hold_length_o), 32'h0000_0002);
		wr(12'h200, 4'hF, 32'hFFFF_FFFF);
		rc("unmapped", 12'h200, 32'h0000_0000);
		$display("key test done");
	endtask : t_key

	// Hang guard.
	initial begin
		repeat (3000) @(posedge clk_i);
		n_fail++;
		give_verdict();
	end

	// Main sequence, with a second reset in mid-run.
	initial begin
		n_fail = 0;
		comparisons = 0;
		bus_addr_i = 12'h000;
		bus_write_i = 1'b0;
		bus_read_i = 1'b0;
		bus_strobe_i = 4'h0;
		bus_wdata_i = 32'h0000_0000;
		do_reset();
		t_reset();
		t_route();
		t_ahb2();
		t_key();
		do_reset();
		t_reset();
		give_verdict();
	end
endmodule : periph_clock_select_and_key_tb
`default_nettype wire
